//--- rtl/sdlc_device.sv
// DAC input logic: serial word capture, data and DAC registers, clear.
//
// Function
// - low power request low stops shifting and loading; clear still acts
// - shift only while frame sync low
// - capture data on serial clock falling edges
// - one sixteen bit word per frame; device takes another word per further sixteen edges in a frame
// - load strobe low copies all data registers
// - load low at sixteenth edge auto-updates
// - clear low clears outputs without clock
// - host keeps clock duty forty to sixty
// - control word selects external reference per DAC
`timescale 1ns/1ps
module sdlc_device
    import sdlc_pkg::*;
#(
    parameter int CHANNELS = SDLC_CHANNELS,
    parameter int CODE_BITS = SDLC_CODE_BITS
) (
    input wire logic sys_clk_in,        // System clock, 125 MHz.
    input wire logic arst_n_in,         // Asynchronous reset, active low.
    sdlc_link_if.device link,           // Serial pins from the host.
    output logic [CHANNELS*CODE_BITS-1:0] dac_code_out, // DAC registers.
    output logic [CHANNELS-1:0] ext_ref_sel_out, // External reference select, one bit per DAC.
    output logic low_power_out,         // Device is in low power state.
    output logic word_done_out          // One pulse per accepted word.
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Bit order: clock, frame, data, load, power.
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic sclk_prev_q;
    logic [NSYNC-1:0] pins_raw;

    assign pins_raw = {link.low_power_request_n, link.load_outputs_n,
                       link.serial_data_in, link.frame_sync_n,
                       link.serial_clock};

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q <= SDLC_PIN_IDLE;
            sync2_q <= SDLC_PIN_IDLE;
            sclk_prev_q <= 1'b1;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sclk_prev_q <= sync2_q[0];
        end
    end

    logic sclk_s;
    logic frame_n_s;
    logic sdata_s;
    logic load_n_s;
    logic power_n_s;
    logic sclk_fall;

    assign sclk_s = sync2_q[0];
    assign frame_n_s = sync2_q[1];
    assign sdata_s = sync2_q[2];
    assign load_n_s = sync2_q[3];
    assign power_n_s = sync2_q[4];
    assign sclk_fall = sclk_prev_q && !sclk_s;

    // ************************************************************
    // Input shift register
    // ************************************************************
    logic [SDLC_WORD_BITS-1:0] shift_q;
    logic [SDLC_WORD_BITS-1:0] shift_d;
    logic [SDLC_CNT_BITS-1:0] cnt_q;
    logic [SDLC_CNT_BITS-1:0] cnt_d;
    logic word_ok;
    logic [SDLC_WORD_BITS-1:0] word_full;
    logic done_d;
    logic done_q;
    logic lowp_q;

    assign word_full = {shift_q[SDLC_WORD_BITS-2:0], sdata_s};

    always_comb begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        word_ok = 1'b0;
        if (!power_n_s) begin
            // In low power the shift register and counter stop toggling, which is the point of it.
            cnt_d = '0;
        end else if (frame_n_s) begin
            // A word cut short by the frame is thrown away, never loaded.
            cnt_d = '0;
        end else if (sclk_fall) begin
            shift_d = word_full;
            if (cnt_q == SDLC_LAST_EDGE) begin
                word_ok = 1'b1;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
        done_d = word_ok;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_q <= '0;
            cnt_q <= '0;
            done_q <= 1'b0;
            lowp_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            lowp_q <= !power_n_s;
        end
    end

    // ************************************************************
    // Data registers, DAC registers and reference select
    // ************************************************************
    logic [CODE_BITS-1:0] data_q [CHANNELS];
    logic [CODE_BITS-1:0] data_d [CHANNELS];
    logic [CODE_BITS-1:0] dac_q [CHANNELS];
    logic [CODE_BITS-1:0] dac_d [CHANNELS];
    logic [CHANNELS-1:0] ref_q;
    logic [CHANNELS-1:0] ref_d;
    logic [SDLC_CH_BITS-1:0] word_ch;
    logic update;

    assign word_ch = word_full[SDLC_ADDR_MSB:SDLC_ADDR_LSB];

    always_comb begin
        data_d = data_q;
        ref_d = ref_q;
        update = 1'b0;
        if (word_ok) begin
            if (word_full[SDLC_CTRL_BIT]) begin
                ref_d[word_ch] = word_full[SDLC_REFSEL_BIT];
            end else begin
                data_d[word_ch] = word_full[CODE_BITS-1:0];
            end
            if (!load_n_s) begin
                update = 1'b1;
            end
        end
        if (power_n_s && !load_n_s) begin
            update = 1'b1;
        end
        dac_d = dac_q;
        if (update) begin
            dac_d = data_d;
        end
    end

    // Data registers only see the system reset; clear acts on outputs.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < CHANNELS; i++) begin
                data_q[i] <= SDLC_ZERO_CODE;
            end
        end else begin
            data_q <= data_d;
        end
    end

    // The clear pin is an asynchronous reset of the output stage, so
    // it acts with no clock at all. Its release passes two flip-flops,
    // so letting go of clear can never race an update edge.
    logic clr_pin_n;
    logic [1:0] clr_rel_q;
    logic clr_arst_n;
    assign clr_pin_n = arst_n_in && link.clear_outputs_n;

    always_ff @(posedge sys_clk_in or negedge clr_pin_n) begin
        if (!clr_pin_n) begin
            clr_rel_q <= 2'h0;
        end else begin
            clr_rel_q <= {clr_rel_q[0], 1'b1};
        end
    end

    assign clr_arst_n = clr_rel_q[1];

    always_ff @(posedge sys_clk_in or negedge clr_arst_n) begin
        if (!clr_arst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                dac_q[i] <= SDLC_CLEAR_CODE;
            end
            ref_q <= '0;
        end else begin
            dac_q <= dac_d;
            ref_q <= ref_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            dac_code_out[i*CODE_BITS +: CODE_BITS] = dac_q[i];
        end
    end

    assign ext_ref_sel_out = ref_q;
    assign low_power_out = lowp_q;
    assign word_done_out = done_q;

endmodule : sdlc_device

//--- rtl/sdlc_host.sv
// Host end: frames 16-bit words onto the serial pins and drives strobes.
`timescale 1ns/1ps
module sdlc_host
    import sdlc_pkg::*;
(
    input wire logic sys_clk_in,        // System clock, 125 MHz.
    input wire logic arst_n_in,         // Asynchronous reset, active low.
    sdlc_link_if.host link,             // Serial pins to the device.
    input wire logic send_in,           // Pulse: send word_in.
    input wire logic [SDLC_WORD_BITS-1:0] word_in, // Word, MSB first.
    input wire logic auto_load_in,      // Hold load low during frames.
    input wire logic strobe_in,         // Pulse: issue a load strobe.
    input wire logic clear_in,          // Level: hold clear asserted.
    input wire logic power_down_in,     // Level: request low power.
    output logic busy_out               // Frame or strobe in progress.
);

    sdlc_host_state_t st_q;
    sdlc_host_state_t st_d;
    logic [SDLC_WORD_BITS-1:0] sh_q;
    logic [SDLC_WORD_BITS-1:0] sh_d;
    logic [SDLC_TMR_BITS-1:0] tmr_q;
    logic [SDLC_TMR_BITS-1:0] tmr_d;
    logic [SDLC_CNT_BITS-1:0] cnt_q;
    logic [SDLC_CNT_BITS-1:0] cnt_d;
    logic sclk_q;
    logic sclk_d;
    logic fs_n_q;
    logic fs_n_d;
    logic ld_n_q;
    logic ld_n_d;
    logic auto_q;
    logic auto_d;
    logic clr_n_q;
    logic pwr_n_q;
    logic tick;
    logic busy_q;
    logic busy_d;

    localparam logic [SDLC_TMR_BITS-1:0] HALF_LAST =
        SDLC_TMR_BITS'(SDLC_HALF_CYC - 1);
    localparam logic [SDLC_TMR_BITS-1:0] STROBE_LAST =
        SDLC_TMR_BITS'(SDLC_STROBE_CYC - 1);

    assign tick = (tmr_q == HALF_LAST);

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    // The serial clock is an even divide of the system clock, giving an
    // exact half-and-half duty cycle.
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        sclk_d = sclk_q;
        fs_n_d = fs_n_q;
        ld_n_d = auto_q ? 1'b0 : 1'b1;
        auto_d = auto_q;
        tmr_d = tick ? '0 : tmr_q + 4'h1;
        unique case (st_q)
            SDLC_IDLE: begin
                tmr_d = '0;
                auto_d = auto_load_in;
                ld_n_d = auto_load_in ? 1'b0 : 1'b1;
                if (send_in) begin
                    st_d = SDLC_SHIFT;
                    sh_d = word_in;
                    cnt_d = '0;
                    fs_n_d = 1'b0;
                end else if (strobe_in) begin
                    st_d = SDLC_STROBE;
                    ld_n_d = 1'b0;
                end
            end
            SDLC_SHIFT: begin
                if (tick) begin
                    sclk_d = !sclk_q;
                    if (!sclk_q) begin
                        // Next bit changes on the rising edge, half a
                        // period away from the capturing fall.
                        sh_d = {sh_q[SDLC_WORD_BITS-2:0], 1'b0};
                        if (cnt_q == SDLC_LAST_EDGE) begin
                            st_d = SDLC_CLOSE;
                        end
                        cnt_d = cnt_q + 5'h01;
                    end
                end
            end
            SDLC_CLOSE: begin
                if (tick) begin
                    fs_n_d = 1'b1;
                    st_d = SDLC_IDLE;
                end
            end
            SDLC_STROBE: begin
                ld_n_d = 1'b0;
                tmr_d = tmr_q + 4'h1;
                if (tmr_q == STROBE_LAST) begin
                    ld_n_d = 1'b1;
                    st_d = SDLC_IDLE;
                end
            end
            default: begin
                st_d = SDLC_IDLE;
            end
        endcase
        busy_d = (st_d != SDLC_IDLE);
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= SDLC_IDLE;
            sh_q <= '0;
            cnt_q <= '0;
            tmr_q <= '0;
            sclk_q <= 1'b1;
            fs_n_q <= 1'b1;
            ld_n_q <= 1'b1;
            auto_q <= 1'b0;
            clr_n_q <= 1'b1;
            pwr_n_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            tmr_q <= tmr_d;
            sclk_q <= sclk_d;
            fs_n_q <= fs_n_d;
            ld_n_q <= ld_n_d;
            auto_q <= auto_d;
            clr_n_q <= !clear_in;
            pwr_n_q <= !power_down_in;
            busy_q <= busy_d;
        end
    end

    assign link.frame_sync_n = fs_n_q;
    assign link.serial_clock = sclk_q;
    assign link.serial_data_in = sh_q[SDLC_WORD_BITS-1];
    assign link.load_outputs_n = ld_n_q;
    assign link.clear_outputs_n = clr_n_q;
    assign link.low_power_request_n = pwr_n_q;
    assign busy_out = busy_q;

endmodule : sdlc_host

//--- rtl/sdlc_link_if.sv
// Pin bundle between the serial DAC host and the DAC input logic.
`timescale 1ns/1ps
interface sdlc_link_if;
    logic frame_sync_n;
    logic serial_clock;
    logic serial_data_in;
    logic load_outputs_n;
    logic clear_outputs_n;
    logic low_power_request_n;

    modport device (
        input frame_sync_n,
        input serial_clock,
        input serial_data_in,
        input load_outputs_n,
        input clear_outputs_n,
        input low_power_request_n
    );

    modport host (
        output frame_sync_n,
        output serial_clock,
        output serial_data_in,
        output load_outputs_n,
        output clear_outputs_n,
        output low_power_request_n
    );
endinterface : sdlc_link_if

//--- rtl/sdlc_pkg.sv
// Shared constants and types for the serial DAC load control block.
package sdlc_pkg;

    // ************************************************************
    // Word format and channel layout
    // ************************************************************
    localparam int SDLC_WORD_BITS = 16;
    localparam int SDLC_CHANNELS = 8;
    localparam int SDLC_CODE_BITS = 10;
    localparam int SDLC_CH_BITS = 3;
    localparam int SDLC_CNT_BITS = 5;
    localparam int SDLC_CTRL_BIT = 15;
    localparam int SDLC_ADDR_MSB = 14;
    localparam int SDLC_ADDR_LSB = 12;
    localparam int SDLC_REFSEL_BIT = 0;
    localparam logic [SDLC_CNT_BITS-1:0] SDLC_LAST_EDGE = 5'h0F;
    localparam logic [SDLC_CODE_BITS-1:0] SDLC_CLEAR_CODE = 10'h200;
    localparam logic [SDLC_CODE_BITS-1:0] SDLC_ZERO_CODE = 10'h000;
    // Idle pin levels; bit order clock, frame, data, load, power.
    localparam logic [4:0] SDLC_PIN_IDLE = 5'h1B;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SDLC_SYS_PERIOD_NS = 8;
    localparam int SDLC_SCLK_PERIOD_NS = 64;
    localparam int SDLC_STROBE_MIN_NS = 40;
    localparam int SDLC_HALF_CYC =
        SDLC_SCLK_PERIOD_NS / (2 * SDLC_SYS_PERIOD_NS);
    localparam int SDLC_STROBE_CYC =
        (SDLC_STROBE_MIN_NS + SDLC_SYS_PERIOD_NS - 1) / SDLC_SYS_PERIOD_NS;
    localparam int SDLC_TMR_BITS = 4;

    typedef enum logic [2:0] {
        SDLC_IDLE,
        SDLC_SHIFT,
        SDLC_CLOSE,
        SDLC_STROBE
    } sdlc_host_state_t;

endpackage : sdlc_pkg

//--- verification/sdlc_link_checker.sv
// Wire checks on the serial link between the host and device ends.
`timescale 1ns/1ps
module sdlc_link_checker
    import sdlc_pkg::*;
(
    input wire logic sys_clk_in,     // System clock.
    input wire logic arst_n_in,      // Host reset, active low.
    input wire logic frame_sync_n,   // Frame sync pin.
    input wire logic serial_clock,   // Serial clock pin.
    input wire logic serial_data_in, // Serial data pin.
    input wire logic load_outputs_n  // Load strobe pin.
);
    // ************************************************************
    // Falling edge counter within a frame
    // ************************************************************
    logic sc_q;
    logic sc_d;
    logic [SDLC_CNT_BITS-1:0] cnt_q;
    logic [SDLC_CNT_BITS-1:0] cnt_d;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    always_comb begin
        sc_d = serial_clock;
        cnt_d = cnt_q;
        if (frame_sync_n) begin
            cnt_d = '0;
        end else if (sc_q && !serial_clock) begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sc_q <= 1'b1;
            cnt_q <= '0;
        end else begin
            sc_q <= sc_d;
            cnt_q <= cnt_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    chk_idle_clock_high:
        assert property (frame_sync_n |-> serial_clock)
        else $error("Serial clock low outside a frame.");
    chk_frame_first_fall:
        assert property ($fell(frame_sync_n) |-> serial_clock ##[1:8]
            $fell(serial_clock))
        else $error("No clock fall soon after frame start.");
    chk_low_half:
        assert property ($fell(serial_clock) |-> !serial_clock[*4]
            ##1 serial_clock)
        else $error("Serial clock low phase is not four cycles.");
    chk_high_half:
        assert property ($rose(serial_clock) |-> serial_clock[*4])
        else $error("Serial clock high phase is short.");
    chk_data_on_rise:
        assert property ($changed(serial_data_in) && !frame_sync_n
            && !$fell(frame_sync_n) |-> $rose(serial_clock))
        else $error("Serial data changed away from a clock rise.");
    chk_sixteen_falls:
        assert property ($rose(frame_sync_n) |-> cnt_q == 5'h10)
        else $error("Frame closed without sixteen clock falls.");
    chk_frame_close:
        assert property ($rose(serial_clock) && cnt_q == 5'h10
            |-> ##[1:8] $rose(frame_sync_n))
        else $error("Frame not closed after the last bit.");
    chk_strobe_width:
        assert property ($fell(load_outputs_n) |-> !load_outputs_n[*5])
        else $error("Load strobe shorter than five cycles.");
endmodule : sdlc_link_checker

//--- verification/tb_top.sv
// Self-checking bench joining the host and device ends of the link.
`timescale 1ns/1ps
module tb_top;
    import sdlc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic host_rst_n = 1'b1;
    logic host_arst_n;
    logic send_in = 1'b0;
    logic [SDLC_WORD_BITS-1:0] word_in = 16'h0000;
    logic auto_load_in = 1'b0;
    logic strobe_in = 1'b0;
    logic clear_in = 1'b0;
    logic power_down_in = 1'b0;
    logic busy_out;
    logic [SDLC_CHANNELS*SDLC_CODE_BITS-1:0] dac_code_out;
    logic [SDLC_CHANNELS-1:0] ext_ref_sel_out;
    logic low_power_out;
    logic word_done_out;
    logic [SDLC_CODE_BITS-1:0] exp_code [SDLC_CHANNELS];
    logic [SDLC_CODE_BITS-1:0] dat_code [SDLC_CHANNELS];
    logic [SDLC_CODE_BITS-1:0] code;
    logic [15:0] done_cnt = 16'h0000;
    logic [15:0] done_exp = 16'h0000;
    int bad_count = 0;
    int comparisons = 0;

    // A separate host reset lets a frame be cut off in mid-word.
    assign host_arst_n = arst_n_in & host_rst_n;
    sdlc_link_if link_bus ();
    sdlc_host i_sdlc_host (.sys_clk_in(sys_clk_in),
        .arst_n_in(host_arst_n), .link(link_bus), .send_in(send_in),
        .word_in(word_in), .auto_load_in(auto_load_in),
        .strobe_in(strobe_in), .clear_in(clear_in),
        .power_down_in(power_down_in), .busy_out(busy_out));
    sdlc_device i_sdlc_device (.sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in), .link(link_bus),
        .dac_code_out(dac_code_out), .ext_ref_sel_out(ext_ref_sel_out),
        .low_power_out(low_power_out), .word_done_out(word_done_out));
    sdlc_link_checker i_sdlc_link_checker (.sys_clk_in(sys_clk_in),
        .arst_n_in(host_arst_n), .frame_sync_n(link_bus.frame_sync_n),
        .serial_clock(link_bus.serial_clock),
        .serial_data_in(link_bus.serial_data_in),
        .load_outputs_n(link_bus.load_outputs_n));

    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        if (word_done_out === 1'b1) begin
            done_cnt <= done_cnt + 16'h0001;
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick

    task automatic wait_idle();
        for (int i = 0; i < 400 && busy_out !== 1'b0; i++) begin
            tick(1);
        end
        tick(8);
    endtask : wait_idle

    task automatic send(input logic [15:0] w, input logic auto);
        word_in = w;
        auto_load_in = auto;
        send_in = 1'b1;
        tick(1);
        send_in = 1'b0;
        auto_load_in = 1'b0;
        tick(1);
        wait_idle();
    endtask : send

    task automatic load_all();
        for (int c = 0; c < SDLC_CHANNELS; c++) begin
            exp_code[c] = dat_code[c];
        end
    endtask : load_all

    task automatic strobe();
        strobe_in = 1'b1;
        tick(1);
        strobe_in = 1'b0;
        tick(1);
        wait_idle();
        load_all();
    endtask : strobe

    task automatic check_codes(input string what);
        for (int c = 0; c < SDLC_CHANNELS; c++) begin
            check(what, dac_code_out[c*SDLC_CODE_BITS +: SDLC_CODE_BITS],
                exp_code[c]);
        end
    endtask : check_codes

    task automatic tally_and_finish();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons,
            bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        for (int c = 0; c < SDLC_CHANNELS; c++) begin
            exp_code[c] = SDLC_CLEAR_CODE;
            dat_code[c] = SDLC_ZERO_CODE;
        end
        tick(12);
        arst_n_in = 1'b1;
        tick(4);
        check_codes("reset code");
        check("reset ref", ext_ref_sel_out, 16'h0000);
        check("reset power", low_power_out, 16'h0000);
        $display("Test reset values done");
        for (int c = 0; c < SDLC_CHANNELS; c++) begin
            code = (c == 7) ? 10'h3FF : 10'(c * 73);
            send({1'b0, 3'(c), 2'b00, code}, 1'b1);
            dat_code[c] = code;
            load_all();
            done_exp++;
            check_codes("auto code");
            check("done count", done_cnt, done_exp);
        end
        $display("Test auto update done");
        send(16'h50AA, 1'b0);
        dat_code[5] = 10'h0AA;
        done_exp++;
        check_codes("held code");
        strobe();
        check_codes("strobe code");
        $display("Test load strobe done");
        send(16'hA001, 1'b1);
        done_exp++;
        check("ref select", ext_ref_sel_out, 16'h0004);
        $display("Test reference select done");
        clear_in = 1'b1;
        // The pin falls at the next edge; only an unclocked clear has
        // already acted one nanosecond later.
        tick(1);
        for (int c = 0; c < SDLC_CHANNELS; c++) begin
            exp_code[c] = SDLC_CLEAR_CODE;
        end
        check_codes("clear code");
        check("clear ref", ext_ref_sel_out, 16'h0000);
        clear_in = 1'b0;
        tick(4);
        strobe();
        check_codes("restored code");
        $display("Test clear done");
        power_down_in = 1'b1;
        tick(6);
        check("low power", low_power_out, 16'h0001);
        send(16'h1123, 1'b1);
        check_codes("power code");
        check("power done", done_cnt, done_exp);
        power_down_in = 1'b0;
        tick(6);
        check("power up", low_power_out, 16'h0000);
        $display("Test low power done");
        word_in = 16'h42A5;
        send_in = 1'b1;
        tick(1);
        send_in = 1'b0;
        tick(40);
        host_rst_n = 1'b0;
        tick(3);
        host_rst_n = 1'b1;
        tick(10);
        check("partial done", done_cnt, done_exp);
        send(16'h415A, 1'b0);
        dat_code[4] = 10'h15A;
        done_exp++;
        check("after abort", done_cnt, done_exp);
        strobe();
        check_codes("after abort code");
        $display("Test aborted frame done");
        tally_and_finish();
    end
endmodule : tb_top
